// [pkg/asc_defs.vh]
// register offsets, field positions, reset values and timing counts for the converter control
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ASC_OFF_CTRL_ONE      4'h0
`define ASC_OFF_CTRL_TWO      4'h4
`define ASC_OFF_CTRL_THREE    4'h8
`define ASC_OFF_STATUS        4'hc

// ****************************************************************
// control one fields
// ****************************************************************
`define ASC_C1_DONE           0
`define ASC_C1_SAMPLE         1
`define ASC_C1_AUTO           2
`define ASC_C1_SIM            3
`define ASC_C1_TRIG_LO        5
`define ASC_C1_TRIG_HI        7
`define ASC_C1_RES12          10
`define ASC_C1_ON             15
`define ASC_C1_WMASK          16'h84ec

// ****************************************************************
// control two fields
// ****************************************************************
`define ASC_C2_ALT            0
`define ASC_C2_SPLIT          1
`define ASC_C2_RATE_LO        2
`define ASC_C2_RATE_HI        5
`define ASC_C2_HALF           7
`define ASC_C2_CNT_LO         8
`define ASC_C2_CNT_HI         9
`define ASC_C2_SCAN           10
`define ASC_C2_REF_LO         13
`define ASC_C2_REF_HI         15
`define ASC_C2_WMASK          16'he73f

// ****************************************************************
// control three fields
// ****************************************************************
`define ASC_C3_DIV_LO         0
`define ASC_C3_DIV_HI         7
`define ASC_C3_SAMT_LO        8
`define ASC_C3_SAMT_HI        12
`define ASC_C3_RC             15
`define ASC_C3_WMASK          16'h9fff

// ****************************************************************
// reset values and codes
// ****************************************************************
`define ASC_RST_REG           16'h0000
`define ASC_TRIG_SOFT         3'h0
`define ASC_TRIG_EXT          3'h1
`define ASC_TRIG_TMR_A        3'h2
`define ASC_TRIG_TMR_B        3'h4
`define ASC_TRIG_COUNTER      3'h7
`define ASC_DIV_MAX           8'h3f
`define ASC_BITS_10           5'h0b
`define ASC_BITS_12           5'h0d

// ****************************************************************
// timing counts
// ****************************************************************
`define ASC_TCY_DIV           2'h3

`endif

// [core/asc_control.v]
// converter sample and convert control with register slave
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ns
// What this block does
// - simultaneous bit samples two or four together
// - twelve-bit mode hides simultaneous and count fields
// - auto-start resamples after last conversion
// - without auto-start, software write starts sampling
// - sample bit shows acquiring versus holding
// - soft trigger: writing zero starts conversion
// - other triggers clear sample bit themselves
// - done flag sets on completion only
// - software clears done, never sets it
// - done clears at each conversion start
// - reference field selects rails or externals
// - scan steps channel zero input in A
// - channel count picks one, two, four
// - buffer-half status shows half being filled
// - interrupt after every rate plus one operations
// - split buffer alternates halves per interrupt
// - alternate mode swaps A and B selections
// - clock source bit picks RC or system
// - auto sample time used only counter trigger
// - divider up to 63 gives period of divider plus one
// - divider ignored when RC clock chosen
// - trigger field selects sampling end source
// - resolution bit selects twelve or ten bits
`include "asc_defs.vh"

module asc_control (
   // clock and reset
   input  wire        mclk,
   input  wire        reset_n,
   // avalon-mm slave
   input  wire [3:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   output reg  [31:0] readdata,
   output wire        waitrequest,
   // trigger sources and rc clock tick
   input  wire        ext_trigger,
   input  wire        timer_a_match,
   input  wire        timer_b_match,
   input  wire        rc_clock_tick,
   // converter core side
   output reg         sh_sampling,
   output reg         conv_busy,
   output reg  [1:0]  sh_channel_active,
   output reg         sample_b_active,
   output reg         sim_sample_out,
   output reg         scan_step,
   output reg  [1:0]  ref_plus_ext,
   output reg         buffer_half_out,
   output reg         conv_irq,
   output reg         conv_clock_tick
);

// ****************************************************************
// state
// ****************************************************************
localparam ST_IDLE   = 2'h0;
localparam ST_SAMPLE = 2'h1;
localparam ST_CONV   = 2'h2;

reg [15:0] ctrl_one_reg;
reg [15:0] adc_control_two_reg;
reg [15:0] adc_control_three_reg;
reg [1:0]  state_reg;
reg [7:0]  tad_cnt_reg;
reg [4:0]  bit_cnt_reg;
reg [4:0]  acq_cnt_reg;
reg [1:0]  chan_reg;
reg [3:0]  rate_cnt_reg;
reg        ack_reg;
reg        ext_d_reg;
reg        alt_b_reg;

wire       res12       = ctrl_one_reg[`ASC_C1_RES12];
wire       mod_on      = ctrl_one_reg[`ASC_C1_ON];
wire       auto_start  = ctrl_one_reg[`ASC_C1_AUTO];
wire [2:0] trig_sel    = ctrl_one_reg[`ASC_C1_TRIG_HI:`ASC_C1_TRIG_LO];
wire       sim_sel     = ctrl_one_reg[`ASC_C1_SIM] & ~res12;
wire [1:0] chan_cnt    = res12 ? 2'h0 :
                         adc_control_two_reg[`ASC_C2_CNT_HI:`ASC_C2_CNT_LO];
wire [3:0] rate_sel    = adc_control_two_reg[`ASC_C2_RATE_HI:`ASC_C2_RATE_LO];
wire       split_mode  = adc_control_two_reg[`ASC_C2_SPLIT];
wire       alt_mode    = adc_control_two_reg[`ASC_C2_ALT];
wire [2:0] ref_sel     = adc_control_two_reg[`ASC_C2_REF_HI:`ASC_C2_REF_LO];
wire       rc_src      = adc_control_three_reg[`ASC_C3_RC];
wire [4:0] acq_time    = adc_control_three_reg[`ASC_C3_SAMT_HI:`ASC_C3_SAMT_LO];
wire [7:0] clk_div     = adc_control_three_reg[`ASC_C3_DIV_HI:`ASC_C3_DIV_LO];

// ****************************************************************
// helpers
// ****************************************************************
function [1:0] last_chan;
   input [1:0] cnt;
   begin
      last_chan = cnt[1] ? 2'h3 : (cnt[0] ? 2'h1 : 2'h0);
   end
endfunction

function [7:0] eff_div;
   input [7:0] d;
   begin
      eff_div = (d > `ASC_DIV_MAX) ? `ASC_DIV_MAX : d;
   end
endfunction

// ****************************************************************
// conversion clock: one tad every (min(divider,63)+1) instruction cycles, or one per rc_clock_tick when RC is chosen
// ****************************************************************
reg [1:0] tcy_cnt_reg;
wire      tcy_tick = (tcy_cnt_reg == `ASC_TCY_DIV);
wire      tad_tick = rc_src ? rc_clock_tick :
                     (tcy_tick && tad_cnt_reg == eff_div(clk_div));

always @(posedge mclk) begin
   if (!reset_n) begin
      tcy_cnt_reg     <= 2'h0;
      tad_cnt_reg     <= 8'h00;
      conv_clock_tick <= 1'b0;
   end else begin
      tcy_cnt_reg     <= tcy_cnt_reg + 2'h1;
      conv_clock_tick <= tad_tick;
      if (rc_src || tad_tick)
         tad_cnt_reg <= 8'h00;
      else if (tcy_tick)
         tad_cnt_reg <= tad_cnt_reg + 8'h01;
   end
end

// ****************************************************************
// trigger selection
// ****************************************************************
wire ext_edge = ext_trigger & ~ext_d_reg;
reg  hw_trig;
always @* begin
   case (trig_sel)
      `ASC_TRIG_EXT:     hw_trig = ext_edge;
      `ASC_TRIG_TMR_A:   hw_trig = timer_a_match;
      `ASC_TRIG_TMR_B:   hw_trig = timer_b_match;
      `ASC_TRIG_COUNTER: hw_trig = tad_tick && (acq_cnt_reg >= acq_time);
      default:           hw_trig = 1'b0;
   endcase
end

// ****************************************************************
// bus decode
// ****************************************************************
wire       wr_c1  = write && address == `ASC_OFF_CTRL_ONE;
wire       wr_c2  = write && address == `ASC_OFF_CTRL_TWO;
wire       wr_c3  = write && address == `ASC_OFF_CTRL_THREE;
wire [15:0] wd    = writedata[15:0];
wire       sw_acq_set    = wr_c1 && wd[`ASC_C1_SAMPLE] && !auto_start;
wire       sw_acq_clr    = wr_c1 && !wd[`ASC_C1_SAMPLE] && trig_sel == `ASC_TRIG_SOFT;
wire       sw_done_clr   = wr_c1 && !wd[`ASC_C1_DONE];

assign waitrequest = (read || write) && !ack_reg;

// ****************************************************************
// sequencer
// ****************************************************************
wire end_sample = (state_reg == ST_SAMPLE) &&
                  ((trig_sel == `ASC_TRIG_SOFT) ? sw_acq_clr : hw_trig);
wire conv_last  = (state_reg == ST_CONV) && tad_tick &&
                  bit_cnt_reg == (res12 ? `ASC_BITS_12 : `ASC_BITS_10);
wire seq_last   = conv_last && chan_reg == last_chan(chan_cnt);
wire rate_hit   = seq_last && rate_cnt_reg == rate_sel;

reg  [1:0] state_next;
always @* begin
   state_next = state_reg;
   case (state_reg)
      ST_IDLE:   if (mod_on && (auto_start || sw_acq_set))
                    state_next = ST_SAMPLE;
      ST_SAMPLE: if (end_sample)
                    state_next = ST_CONV;
      ST_CONV:   if (seq_last)
                    state_next = auto_start ? ST_SAMPLE : ST_IDLE;
                 else if (conv_last && !sim_sel)
                    state_next = ST_CONV;
      default:   state_next = ST_IDLE;
   endcase
   if (!mod_on)
      state_next = ST_IDLE;
end

always @(posedge mclk) begin
   if (!reset_n) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 5'h00;
      acq_cnt_reg  <= 5'h00;
      chan_reg     <= 2'h0;
      rate_cnt_reg <= 4'h0;
      alt_b_reg    <= 1'b0;
      ext_d_reg    <= 1'b0;
      ack_reg      <= 1'b0;
   end else begin
      state_reg <= state_next;
      ext_d_reg <= ext_trigger;
      ack_reg   <= (read || write) && !ack_reg;
      if (state_reg == ST_SAMPLE) begin
         if (tad_tick && acq_cnt_reg != 5'h1f)
            acq_cnt_reg <= acq_cnt_reg + 5'h01;
      end else
         acq_cnt_reg <= 5'h00;
      if (end_sample) begin
         bit_cnt_reg <= 5'h00;
         chan_reg    <= 2'h0;
      end else if (conv_last) begin
         bit_cnt_reg <= 5'h00;
         chan_reg    <= chan_reg + 2'h1; // sequential channel step
      end else if (state_reg == ST_CONV && tad_tick)
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
      if (seq_last) begin
         rate_cnt_reg <= rate_hit ? 4'h0 : rate_cnt_reg + 4'h1;
         alt_b_reg    <= alt_mode ? ~alt_b_reg : 1'b0;
      end else if (!alt_mode)
         alt_b_reg <= 1'b0;
   end
end

// ****************************************************************
// registers
// ****************************************************************
wire sample_bit = (state_reg == ST_SAMPLE);

always @(posedge mclk) begin
   if (!reset_n) begin
      ctrl_one_reg          <= `ASC_RST_REG;
      adc_control_two_reg   <= `ASC_RST_REG;
      adc_control_three_reg <= `ASC_RST_REG;
   end else begin
      if (wr_c1)
         ctrl_one_reg <= (ctrl_one_reg & ~`ASC_C1_WMASK) | (wd & `ASC_C1_WMASK);
      if (wr_c3)
         adc_control_three_reg <= wd & `ASC_C3_WMASK;
      // done: set wins over software clear
      if (seq_last)
         ctrl_one_reg[`ASC_C1_DONE] <= 1'b1;
      else if (end_sample)
         ctrl_one_reg[`ASC_C1_DONE] <= 1'b0;
      else if (sw_done_clr)
         ctrl_one_reg[`ASC_C1_DONE] <= 1'b0;
      // buffer half kept out of write mask
      if (wr_c2)
         adc_control_two_reg <= (adc_control_two_reg & ~`ASC_C2_WMASK) |
                                (wd & `ASC_C2_WMASK);
      if (rate_hit)
         adc_control_two_reg[`ASC_C2_HALF] <= split_mode ?
            ~adc_control_two_reg[`ASC_C2_HALF] : 1'b0;
      else if (wr_c2 && !wd[`ASC_C2_SPLIT])
         adc_control_two_reg[`ASC_C2_HALF] <= 1'b0;
   end
end

// ****************************************************************
// read mux
// ****************************************************************
wire [15:0] c1_view = {ctrl_one_reg[15:4], sim_sel, ctrl_one_reg[`ASC_C1_AUTO],
                       sample_bit, ctrl_one_reg[`ASC_C1_DONE]};
wire [15:0] c2_view = {adc_control_two_reg[15:10], chan_cnt,
                       adc_control_two_reg[7:0]};
reg  [15:0] rd_mux;
always @* begin
   case (address)
      `ASC_OFF_CTRL_ONE:   rd_mux = c1_view;
      `ASC_OFF_CTRL_TWO:   rd_mux = c2_view;
      `ASC_OFF_CTRL_THREE: rd_mux = adc_control_three_reg;
      `ASC_OFF_STATUS:     rd_mux = {12'h000, alt_b_reg, chan_reg, conv_busy};
      default:             rd_mux = 16'h0000;
   endcase
end

always @(posedge mclk) begin
   if (!reset_n)
      readdata <= 32'h00000000;
   else if (read && !ack_reg)
      readdata <= {16'h0000, rd_mux};
end

// ****************************************************************
// converter core outputs
// ****************************************************************
always @(posedge mclk) begin
   if (!reset_n) begin
      sh_sampling       <= 1'b0;
      conv_busy         <= 1'b0;
      sh_channel_active <= 2'h0;
      sample_b_active   <= 1'b0;
      sim_sample_out    <= 1'b0;
      scan_step         <= 1'b0;
      ref_plus_ext      <= 2'h0;
      buffer_half_out   <= 1'b0;
      conv_irq          <= 1'b0;
   end else begin
      sh_sampling       <= (state_next == ST_SAMPLE);
      conv_busy         <= (state_next == ST_CONV);
      sh_channel_active <= chan_reg;
      sample_b_active   <= alt_b_reg;
      sim_sample_out    <= sim_sel && chan_cnt != 2'h0;
      scan_step         <= adc_control_two_reg[`ASC_C2_SCAN] && seq_last && !alt_b_reg;
      ref_plus_ext      <= ref_sel[2] ? 2'h0 : ref_sel[1:0];
      buffer_half_out   <= adc_control_two_reg[`ASC_C2_HALF];
      conv_irq          <= rate_hit;
   end
end

endmodule // asc_control

// [verification/asc_control_asserts.sv]
// port-level assertions for the converter control block
`timescale 1ns/1ns
module asc_control_asserts (
   // clock and reset
   input wire        mclk,
   input wire        reset_n,
   // bus side
   input wire        read,
   input wire        write,
   input wire [31:0] readdata,
   input wire        waitrequest,
   // converter side
   input wire        sh_sampling,
   input wire        conv_busy,
   input wire        conv_irq
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   // request in its first cycle, then still held
   sequence s_req_open;
      (read || write) && waitrequest;
   endsequence
   sequence s_req_held;
      s_req_open ##1 (read || write);
   endsequence

   a_wait_first: assert property ((read || write) && !$past(read || write) |-> waitrequest)
      else $error("waitrequest low in first request cycle");
   a_wait_second: assert property (s_req_held |-> !waitrequest)
      else $error("waitrequest high in second request cycle");
   a_wait_idle: assert property (!(read || write) |-> !waitrequest)
      else $error("waitrequest high without request");
   a_rdata_hold: assert property (!read |=> $stable(readdata))
      else $error("read data changed without read");
   a_rdata_upper: assert property (readdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   a_hold_excl: assert property (!(sh_sampling && conv_busy))
      else $error("sampling and converting together");
   a_irq_single: assert property (conv_irq |=> !conv_irq)
      else $error("interrupt pulse longer than one cycle");
   a_irq_end: assert property (conv_irq |-> $past(conv_busy) || $past(conv_busy, 2))
      else $error("interrupt without finished conversion");
endmodule // asc_control_asserts

bind asc_control asc_control_asserts u_asc_chk (
   .mclk(mclk), .reset_n(reset_n), .read(read), .write(write), .readdata(readdata),
   .waitrequest(waitrequest), .sh_sampling(sh_sampling), .conv_busy(conv_busy),
   .conv_irq(conv_irq)
);

// [verification/tb_top.sv]
// self-checking bench for the converter control block
`timescale 1ns/1ns
module tb_top;
   reg         mclk = 1'b0;
   reg         reset_n = 1'b0;
   reg  [3:0]  address = 4'h0;
   reg         read = 1'b0;
   reg         write = 1'b0;
   reg  [31:0] writedata = 32'h0;
   reg         ext_trigger = 1'b0;
   reg         timer_a_match = 1'b0;
   reg         timer_b_match = 1'b0;
   reg         rc_clock_tick = 1'b0;
   wire [31:0] readdata;
   wire        waitrequest, sh_sampling, conv_busy, sample_b_active, sim_sample_out;
   wire        scan_step, buffer_half_out, conv_irq, conv_clock_tick;
   wire [1:0]  sh_channel_active, ref_plus_ext;
   int         bad_count = 0, comparisons = 0, end_n = 0, irq_n = 0, tick_n = 0;
   int         cyc = 0, last_tick = 0, gap = 0, i, t0;
   int         last_ch = 0, scan_n = 0, tad_n = 0, t1;
   reg  [15:0] q;
   reg  [2:0]  tc;

   always #2 mclk = ~mclk;

   asc_control dut (
      .mclk(mclk), .reset_n(reset_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .ext_trigger(ext_trigger), .timer_a_match(timer_a_match),
      .timer_b_match(timer_b_match), .rc_clock_tick(rc_clock_tick),
      .sh_sampling(sh_sampling), .conv_busy(conv_busy),
      .sh_channel_active(sh_channel_active), .sample_b_active(sample_b_active),
      .sim_sample_out(sim_sample_out), .scan_step(scan_step), .ref_plus_ext(ref_plus_ext),
      .buffer_half_out(buffer_half_out), .conv_irq(conv_irq),
      .conv_clock_tick(conv_clock_tick)
   );

   // ****************************************************************
   // event counters and tasks
   // ****************************************************************
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (conv_irq === 1'b1) irq_n <= irq_n + 1;
      if ($fell(conv_busy)) end_n <= end_n + 1;
      if (conv_busy === 1'b1) last_ch <= sh_channel_active;
      if (scan_step === 1'b1) scan_n <= scan_n + 1;
      if (conv_clock_tick === 1'b1 && $past(conv_busy) === 1'b1) tad_n <= tad_n + 1;
      if (conv_clock_tick === 1'b1) begin
         tick_n <= tick_n + 1;
         gap <= cyc - last_tick;
         last_tick <= cyc;
      end
   end

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic timeout(input string what);
      bad_count++;
      $display("MISMATCH %s expected response seen timeout", what);
      summarize;
   endtask

   task automatic chk(input string what, input [15:0] exp, input [15:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic is_rd, input [3:0] a, input [15:0] d, output [15:0] rq);
      int t;
      t = 0;
      address <= a;
      writedata <= {16'h0000, d};
      read <= is_rd;
      write <= !is_rd;
      @(posedge mclk);
      while (waitrequest !== 1'b0) begin
         @(posedge mclk);
         t++;
         if (t > 20) timeout("bus");
      end
      rq = readdata[15:0];
      read <= 1'b0;
      write <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic wr(input [3:0] a, input [15:0] d);
      logic [15:0] dummy;
      bus(1'b0, a, d, dummy);
   endtask

   task automatic rd(input [3:0] a, output [15:0] rq);
      bus(1'b1, a, 16'h0000, rq);
   endtask

   // sel 0 conversion ends, 1 interrupts, 2 clock ticks
   task automatic wait_for(input int sel, input int n);
      int t;
      t = 0;
      while ((sel == 0 ? end_n : sel == 1 ? irq_n : tick_n) < n) begin
         @(posedge mclk);
         t++;
         if (t > 3000) timeout("event wait");
      end
   endtask

   task automatic fire(input [2:0] c);
      case (c)
         3'h0: wr(4'h0, 16'h8001);
         3'h1: ext_trigger <= 1'b1;
         3'h2: timer_a_match <= 1'b1;
         default: timer_b_match <= 1'b1;
      endcase
      @(posedge mclk);
      timer_a_match <= 1'b0;
      timer_b_match <= 1'b0;
   endtask

   // ****************************************************************
   // test sequence
   // ****************************************************************
   initial begin
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      for (i = 0; i < 5; i++) begin
         rd((i == 4) ? 4'h2 : 4'(i * 4), q);
         chk("reset value", 16'h0000, q);
      end
      wr(4'h8, 16'hff3f);
      rd(4'h8, q);
      chk("control three", 16'h9f3f, q);
      wr(4'h4, 16'hffff);
      rd(4'h4, q);
      chk("control two", 16'he73f, q);
      wr(4'h0, 16'h0408);
      rd(4'h0, q);
      chk("control one 12-bit", 16'h0400, q);
      rd(4'h4, q);
      chk("control two 12-bit", 16'he43f, q);
      for (i = 0; i < 8; i++) begin
         wr(4'h4, 16'(i << 13));
         repeat (2) @(posedge mclk);
         chk("reference", (i < 4) ? 16'(i & 3) : 16'h0000, 16'(ref_plus_ext));
      end
      $display("test registers finished");
      wr(4'h8, 16'h0000);
      wr(4'h0, 16'h8002);
      rd(4'h0, q);
      chk("sample bit set", 16'h8002, q);
      chk("sampling", 16'h0001, 16'(sh_sampling));
      irq_n = 0;
      t0 = end_n;
      wr(4'h0, 16'h8000);
      rd(4'h0, q);
      chk("converting", 16'h8000, q);
      chk("busy", 16'h0001, 16'(conv_busy));
      wait_for(0, t0 + 1);
      repeat (4) @(posedge mclk);
      rd(4'h0, q);
      chk("done", 16'h8001, q);
      chk("no restart", 16'h0000, 16'(sh_sampling));
      chk("interrupts", 16'h0001, 16'(irq_n));
      wr(4'h0, 16'h8000);
      wr(4'h0, 16'h8001);
      rd(4'h0, q);
      chk("done written one", 16'h8000, q);
      $display("test software finished");
      wr(4'h4, 16'h0701);
      for (i = 0; i < 3; i++) begin
         q = (i == 2) ? 16'h8400 : 16'h8008;
         t0 = end_n;
         wr(4'h0, q | 16'h0002);
         chk("simultaneous", 16'(i < 2), 16'(sim_sample_out));
         t1 = tad_n;
         wr(4'h0, q);
         wait_for(0, t0 + 1);
         repeat (2) @(posedge mclk);
         chk("conversion tads", (i < 2) ? 16'h0030 : 16'h000e, 16'(tad_n - t1));
         chk("last channel", (i < 2) ? 16'h0003 : 16'h0000, 16'(last_ch));
         chk("sample b", 16'(i != 1), 16'(sample_b_active));
         chk("scan steps", 16'(1 + i / 2), 16'(scan_n));
      end
      $display("test channels finished");
      for (i = 0; i < 4; i++) begin
         tc = (i == 3) ? 3'h4 : 3'(i);
         t0 = end_n;
         wr(4'h0, 16'h8003 | {8'h00, tc, 5'h00});
         fire(tc);
         repeat (2) @(posedge mclk);
         chk("trigger ends sampling", 16'h0000, 16'(sh_sampling));
         rd(4'h0, q);
         chk("trigger status", 16'h8000 | {8'h00, tc, 5'h00}, q);
         wait_for(0, t0 + 1);
         ext_trigger <= 1'b0;
         repeat (4) @(posedge mclk);
      end
      $display("test triggers finished");
      wr(4'h8, 16'h0100);
      wr(4'h4, 16'h000a);
      end_n = 0;
      irq_n = 0;
      wr(4'h0, 16'h80e6);
      for (i = 1; i < 4; i++) begin
         wait_for(1, i);
         repeat (2) @(posedge mclk);
         chk("operations per interrupt", 16'(3 * i), 16'(end_n));
         chk("buffer half", 16'(i % 2), 16'(buffer_half_out));
         rd(4'h4, q);
         chk("buffer half bit", 16'(i % 2), 16'(q[7]));
      end
      wr(4'h0, 16'h8000);
      $display("test auto finished");
      for (i = 0; i < 3; i++) begin
         wr(4'h8, (i == 2) ? 16'h003f : 16'(i * 2));
         wait_for(2, tick_n + 3);
         chk("tick period", (i == 2) ? 16'h0100 : 16'(4 * (2 * i + 1)), 16'(gap));
      end
      wr(4'h8, 16'h8000);
      repeat (8) @(posedge mclk);
      t0 = tick_n;
      rc_clock_tick <= 1'b1;
      @(posedge mclk);
      rc_clock_tick <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("rc ticks", 16'h0001, 16'(tick_n - t0));
      $display("test clocks finished");
      summarize;
   end
endmodule // tb_top
